// *** hw/pec_top.v ***
// performance event counters with apb register access
// ----------------------------------------------------------------
// Summary of operation
// - three counters 16/16/14 bits in control word
// - counter zero control: off, run, 65536, 256
// - counter one control same four encodings
// - counter two control: off, run, 16384, 256
// - user kill stops counting in user mode
// - library kill stops counting in library mode
// - os kill; all three set kills kernel only
// - counter zero counts cycles or issued instructions
// - counter one codes 0-7 pipeline issue events
// - code 8 depends on counter two select
// - codes 9-e unit events, f cache box one
// - counter two codes 0, 2-7; 1 reserved
// - counter two codes 8-a, c-f events
// - code b counts held sysclk-sampled monitor pin
// - suppression follows the mode actually in effect
// - pending requests shown at summary bits 27-29
// - write one to clear bits 27-29 clears request
// ----------------------------------------------------------------
`timescale 1ns/10ps
`default_nettype none
`include "pec_defines.vh"
module pec_top (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire [1:0] cpu_mode,
  input wire privileged_library_mode,
  input wire instr_issued,
  input wire [15:0] one_events,
  input wire jsr_ret_event,
  input wire cond_branch_event,
  input wire flow_change_event,
  input wire [15:0] two_events,
  input wire sysclk_edge,
  input wire perf_mon,
  output reg irq_zero,
  output reg irq_one,
  output reg irq_two
);
  // ----------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------
  reg event_select_zero_reg;
  reg user_kill_reg;
  reg library_kill_reg;
  reg os_kill_reg;
  reg [1:0] count_ctrl_zero_reg;
  reg [1:0] count_ctrl_one_reg;
  reg [1:0] count_ctrl_two_reg;
  reg [3:0] event_select_one_reg;
  reg [3:0] event_select_two_reg;
  reg [2:0] pend_reg;
  reg mon_hold_reg;
  wire [15:0] event_count_zero;
  wire [15:0] event_count_one;
  wire [13:0] event_count_two;
  wire [63:0] perf_counter_control;
  wire wr_en;
  wire rd_en;
  wire wr_lo;
  wire wr_hi;
  wire wr_clr;
  wire hit_map;
  wire killed;
  wire one_hit;
  wire two_hit;
  wire [15:0] two_events_m;
  wire inc0;
  wire inc1;
  wire inc2;
  wire f0;
  wire b0;
  wire f1;
  wire b1;
  wire f2;
  wire b2;
  wire [2:0] irq_set;
  wire [2:0] irq_clr;
  reg [31:0] rd_mux;

  // ----------------------------------------------------------------
  // apb decode: zero wait states, unmapped address errors
  // ----------------------------------------------------------------
  // unaligned or unmapped offsets miss hit_map and are refused
  assign hit_map = (paddr == `PEC_CTRL_LO_ADDR) | (paddr == `PEC_CTRL_HI_ADDR) |
                   (paddr == `PEC_ISR_ADDR) | (paddr == `PEC_ICLR_ADDR) |
                   (paddr == `PEC_MODE_ADDR);
  assign wr_en = psel & penable & pwrite & hit_map;
  assign rd_en = psel & ~penable & ~pwrite;
  assign wr_lo = wr_en & (paddr == `PEC_CTRL_LO_ADDR);
  assign wr_hi = wr_en & (paddr == `PEC_CTRL_HI_ADDR);
  assign wr_clr = wr_en & (paddr == `PEC_ICLR_ADDR);

  assign perf_counter_control = {event_count_zero, event_count_one, event_select_zero_reg,
                                 user_kill_reg, event_count_two, count_ctrl_zero_reg,
                                 count_ctrl_one_reg, count_ctrl_two_reg, library_kill_reg,
                                 os_kill_reg, event_select_one_reg, event_select_two_reg};

  always @*
  begin
    rd_mux = 32'h00000000;
    case (paddr)
      `PEC_CTRL_LO_ADDR: rd_mux = perf_counter_control[31:0];
      `PEC_CTRL_HI_ADDR: rd_mux = perf_counter_control[63:32];
      `PEC_ISR_ADDR: rd_mux = {2'h0, pend_reg, 27'h0000000};
      `PEC_MODE_ADDR: rd_mux = {29'h00000000, privileged_library_mode, cpu_mode};
      default: rd_mux = 32'h00000000;
    endcase
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      // pready answers in the first access cycle
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & ~hit_map;
      // read data captured at setup so it stands with pready
      if (rd_en)
        prdata <= rd_mux;
    end
  end

  // ----------------------------------------------------------------
  // control fields of the low word
  // ----------------------------------------------------------------
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      event_select_zero_reg <= 1'b0;
      user_kill_reg <= 1'b0;
      count_ctrl_zero_reg <= `PEC_CTL_OFF;
      count_ctrl_one_reg <= `PEC_CTL_OFF;
      count_ctrl_two_reg <= `PEC_CTL_OFF;
      library_kill_reg <= 1'b0;
      os_kill_reg <= 1'b0;
      event_select_one_reg <= 4'h0;
      event_select_two_reg <= 4'h0;
    end
    else if (wr_lo & pready)
    begin
      event_select_zero_reg <= pwdata[`PEC_EVENT_SELECT_ZERO_BIT];
      user_kill_reg <= pwdata[`PEC_KU_BIT];
      count_ctrl_zero_reg <= pwdata[`PEC_COUNT_CTRL_ZERO_MSB:`PEC_COUNT_CTRL_ZERO_LSB];
      count_ctrl_one_reg <= pwdata[`PEC_COUNT_CTRL_ONE_MSB:`PEC_COUNT_CTRL_ONE_LSB];
      count_ctrl_two_reg <= pwdata[`PEC_COUNT_CTRL_TWO_MSB:`PEC_COUNT_CTRL_TWO_LSB];
      library_kill_reg <= pwdata[`PEC_KP_BIT];
      os_kill_reg <= pwdata[`PEC_KK_BIT];
      event_select_one_reg <= pwdata[`PEC_EVENT_SELECT_ONE_MSB:`PEC_EVENT_SELECT_ONE_LSB];
      event_select_two_reg <= pwdata[`PEC_EVENT_SELECT_TWO_MSB:`PEC_EVENT_SELECT_TWO_LSB];
    end
  end

  // ----------------------------------------------------------------
  // mode kill logic
  // ----------------------------------------------------------------
  // library mode wins over the architectural mode, whoever called it
  // all three kill bits set narrow the os kill to kernel only
  assign killed = privileged_library_mode ? library_kill_reg :
    ((cpu_mode == `PEC_MODE_USER) ? user_kill_reg :
     ((user_kill_reg & library_kill_reg & os_kill_reg) ?
      (cpu_mode == `PEC_MODE_KERNEL) : os_kill_reg));

  // ----------------------------------------------------------------
  // event sources
  // ----------------------------------------------------------------
  // monitor pin held for a whole system clock period
  // a level between system clock edges is never seen by the counter
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      mon_hold_reg <= 1'b0;
    else if (sysclk_edge)
      mon_hold_reg <= perf_mon;
  end

  assign two_events_m = {two_events[15:12], mon_hold_reg, two_events[10:2],
                         1'b0, two_events[0]};

  pec_sel_mux u_mux (
    .event_select_one(event_select_one_reg),
    .event_select_two(event_select_two_reg),
    .one_events(one_events),
    .jsr_ret_event(jsr_ret_event),
    .cond_branch_event(cond_branch_event),
    .flow_change_event(flow_change_event),
    .two_events(two_events_m),
    .one_hit(one_hit),
    .two_hit(two_hit)
  );

  assign inc0 = ~killed & (count_ctrl_zero_reg != `PEC_CTL_OFF) &
                (event_select_zero_reg ? instr_issued : 1'b1);
  assign inc1 = ~killed & (count_ctrl_one_reg != `PEC_CTL_OFF) & one_hit;
  assign inc2 = ~killed & (count_ctrl_two_reg != `PEC_CTL_OFF) & two_hit;

  // ----------------------------------------------------------------
  // counters
  // ----------------------------------------------------------------
  // a word write wins over the increment of the same cycle
  pec_counter #(.W(16)) u_c0 (
    .pclk(pclk),
    .presetn(presetn),
    .load(wr_hi & pready),
    .load_value(pwdata[31:16]),
    .inc(inc0),
    .count_reg(event_count_zero),
    .wrap_full(f0),
    .wrap_byte(b0)
  );
  pec_counter #(.W(16)) u_c1 (
    .pclk(pclk),
    .presetn(presetn),
    .load(wr_hi & pready),
    .load_value(pwdata[15:0]),
    .inc(inc1),
    .count_reg(event_count_one),
    .wrap_full(f1),
    .wrap_byte(b1)
  );
  // counter two lives in the low word, so a low write reloads it
  pec_counter #(.W(14)) u_c2 (
    .pclk(pclk),
    .presetn(presetn),
    .load(wr_lo & pready),
    .load_value(pwdata[`PEC_EVENT_COUNT_TWO_MSB:`PEC_EVENT_COUNT_TWO_LSB]),
    .inc(inc2),
    .count_reg(event_count_two),
    .wrap_full(f2),
    .wrap_byte(b2)
  );

  // ----------------------------------------------------------------
  // pending requests
  // ----------------------------------------------------------------
  // threshold choice is the same for all three counters
  function irq_pick;
    input [1:0] ctl;
    input full;
    input roll;
    begin
      case (ctl)
        `PEC_CTL_FULL: irq_pick = full;
        `PEC_CTL_256: irq_pick = roll;
        default: irq_pick = 1'b0;
      endcase
    end
  endfunction

  assign irq_set[0] = irq_pick(count_ctrl_zero_reg, f0, b0);
  assign irq_set[1] = irq_pick(count_ctrl_one_reg, f1, b1);
  assign irq_set[2] = irq_pick(count_ctrl_two_reg, f2, b2);
  assign irq_clr = {3{wr_clr & pready}} &
                   pwdata[`PEC_IRQ2_BIT:`PEC_IRQ0_BIT];

  // set beats a same-cycle clear so no roll-over is lost
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pend_reg <= 3'h0;
    else
      pend_reg <= irq_set | (pend_reg & ~irq_clr);
  end

  // ----------------------------------------------------------------
  // request outputs
  // ----------------------------------------------------------------
  // outputs carry the pending next state, so they leave straight from flops
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq_zero <= 1'b0;
      irq_one <= 1'b0;
      irq_two <= 1'b0;
    end
    else
    begin
      irq_zero <= irq_set[0] | (pend_reg[0] & ~irq_clr[0]);
      irq_one <= irq_set[1] | (pend_reg[1] & ~irq_clr[1]);
      irq_two <= irq_set[2] | (pend_reg[2] & ~irq_clr[2]);
    end
  end
endmodule // pec_top
`default_nettype wire

// *** hw/pec_defines.vh ***
// register map, field positions and timing constants of the event counters
`ifndef PEC_DEFINES_VH
`define PEC_DEFINES_VH
// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define PEC_CTRL_LO_ADDR 12'h000
`define PEC_CTRL_HI_ADDR 12'h004
`define PEC_ISR_ADDR 12'h008
`define PEC_ICLR_ADDR 12'h00c
`define PEC_MODE_ADDR 12'h010
// ----------------------------------------------------------------
// fields of the 64-bit control register
// ----------------------------------------------------------------
`define PEC_EVENT_COUNT_ZERO_MSB 63
`define PEC_EVENT_COUNT_ZERO_LSB 48
`define PEC_EVENT_COUNT_ONE_MSB 47
`define PEC_EVENT_COUNT_ONE_LSB 32
`define PEC_EVENT_SELECT_ZERO_BIT 31
`define PEC_KU_BIT 30
`define PEC_EVENT_COUNT_TWO_MSB 29
`define PEC_EVENT_COUNT_TWO_LSB 16
`define PEC_COUNT_CTRL_ZERO_MSB 15
`define PEC_COUNT_CTRL_ZERO_LSB 14
`define PEC_COUNT_CTRL_ONE_MSB 13
`define PEC_COUNT_CTRL_ONE_LSB 12
`define PEC_COUNT_CTRL_TWO_MSB 11
`define PEC_COUNT_CTRL_TWO_LSB 10
`define PEC_KP_BIT 9
`define PEC_KK_BIT 8
`define PEC_EVENT_SELECT_ONE_MSB 7
`define PEC_EVENT_SELECT_ONE_LSB 4
`define PEC_EVENT_SELECT_TWO_MSB 3
`define PEC_EVENT_SELECT_TWO_LSB 0
`define PEC_CTRL_RESET 64'h0000000000000000
// ----------------------------------------------------------------
// summary and clear bits, control encodings, modes
// ----------------------------------------------------------------
`define PEC_IRQ0_BIT 27
`define PEC_IRQ1_BIT 28
`define PEC_IRQ2_BIT 29
`define PEC_CTL_OFF 2'h0
`define PEC_CTL_RUN 2'h1
`define PEC_CTL_FULL 2'h2
`define PEC_CTL_256 2'h3
`define PEC_MODE_KERNEL 2'h0
`define PEC_MODE_EXEC 2'h1
`define PEC_MODE_SUPER 2'h2
`define PEC_MODE_USER 2'h3
`define PEC_EVENT_SELECT_TWO_TGT_MISP 4'h2
`define PEC_EVENT_SELECT_TWO_BR_MISP 4'h3
`define PEC_EVENT_SELECT_TWO_EXT_MON 4'hb
`define PEC_LONG_STALL_CYC 15
`endif

// *** hw/pec_counter.v ***
// one wrapping event counter with a low-byte and a full-wrap carry
`timescale 1ns/10ps
`default_nettype none
module pec_counter #(
  parameter W = 16
) (
  input wire pclk,
  input wire presetn,
  input wire load,
  input wire [W-1:0] load_value,
  input wire inc,
  output reg [W-1:0] count_reg,
  output wire wrap_full,
  output wire wrap_byte
);
  // full wrap and low byte roll-over both happen on the increment
  assign wrap_full = inc & (&count_reg);
  assign wrap_byte = inc & (&count_reg[7:0]);

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      count_reg <= {W{1'b0}};
    else if (load)
      count_reg <= load_value;
    else if (inc)
      count_reg <= count_reg + {{(W-1){1'b0}}, 1'b1};
  end
endmodule // pec_counter
`default_nettype wire

// *** hw/pec_sel_mux.v ***
// event selection for counters one and two
`timescale 1ns/10ps
`default_nettype none
`include "pec_defines.vh"
module pec_sel_mux (
  input wire [3:0] event_select_one,
  input wire [3:0] event_select_two,
  input wire [15:0] one_events,
  input wire jsr_ret_event,
  input wire cond_branch_event,
  input wire flow_change_event,
  input wire [15:0] two_events,
  output reg one_hit,
  output reg two_hit
);
  always @*
  begin
    one_hit = one_events[event_select_one];
    if (event_select_one == 4'h8)
    begin
      // only cross-counter dependency
      if (event_select_two == `PEC_EVENT_SELECT_TWO_TGT_MISP)
        one_hit = jsr_ret_event;
      else if (event_select_two == `PEC_EVENT_SELECT_TWO_BR_MISP)
        one_hit = cond_branch_event;
      else
        one_hit = flow_change_event;
    end
    two_hit = two_events[event_select_two];
  end
endmodule // pec_sel_mux
`default_nettype wire

// *** testbench/pec_monitor.sv ***
// checker of bus answers and request clearing at the counter block pins
`timescale 1ns/10ps
`default_nettype none
module pec_monitor (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic irq_zero,
  input wire logic irq_one,
  input wire logic irq_two
);
  logic clr_w;
  logic c0;
  logic c1;
  logic c2;
  assign clr_w = psel && penable && pready && pwrite && paddr == 12'h00c;
  assign c0 = clr_w && pwdata[27];
  assign c1 = clr_w && pwdata[28];
  assign c2 = clr_w && pwdata[29];
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // ----
  // bus answer
  // ----
  pready_pulse_a: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  ready_answer_a: assert property (psel && !penable |=> pready)
    else $error("no answer after setup");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  err_unmap_a: assert property (psel && !penable && paddr > 12'h010 |=> pslverr)
    else $error("unmapped access not refused");
  ok_mapped_a: assert property (psel && !penable && paddr <= 12'h010 && paddr[1:0] == 2'h0
    |=> !pslverr)
    else $error("mapped access refused");
  err_data_a: assert property (pslverr && !pwrite |-> prdata == 32'h0)
    else $error("refused read returned data");
  // ----
  // pending requests drop only on a clear
  // ----
  clr_zero_a: assert property ($fell(irq_zero) |-> c0 || $past(c0))
    else $error("irq_zero dropped without clear");
  clr_one_a: assert property ($fell(irq_one) |-> c1 || $past(c1))
    else $error("irq_one dropped without clear");
  clr_two_a: assert property ($fell(irq_two) |-> c2 || $past(c2))
    else $error("irq_two dropped without clear");
endmodule // pec_monitor
`default_nettype wire

// *** testbench/pec_sys_model.sv ***
// far side: system clock boundary and external monitor level
`timescale 1ns/10ps
`default_nettype none
module pec_sys_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic arm,
  output wire logic sysclk_edge,
  output wire logic perf_mon
);
  logic [1:0] div_reg;
  logic shot_reg;
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      div_reg <= 2'h0;
      shot_reg <= 1'b0;
    end
    else
    begin
      div_reg <= div_reg + 2'h1;
      if (arm)
        shot_reg <= 1'b1;
      else if (div_reg == 2'h3)
        shot_reg <= 1'b0;
    end
  end
  assign sysclk_edge = div_reg == 2'h3;
  // stray pulse off the boundary must never be counted
  assign perf_mon = (div_reg == 2'h1) || (shot_reg && div_reg == 2'h3);
endmodule // pec_sys_model
`default_nettype wire

// *** testbench/pec_top_tb_top.sv ***
// bench of the event counters: apb sequences with expected values
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin n_fail++; \
  $display("Error %s exp %h got %h", n, e, g); end end
module pec_top_tb_top;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, q, lo;
  logic pready, pslverr, er, irq_zero, irq_one, irq_two, sysclk_edge, perf_mon, kill;
  logic [1:0] cpu_mode = 2'h0;
  logic lib = 1'b0, ins = 1'b0, arm = 1'b0;
  logic [15:0] e1 = 16'h0, e2 = 16'h0;
  logic [2:0] br = 3'h0;
  int n_fail = 0, total_checks = 0;
  pec_top pec_top_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .cpu_mode, .privileged_library_mode(lib),
    .instr_issued(ins), .one_events(e1), .jsr_ret_event(br[2]),
    .cond_branch_event(br[1]), .flow_change_event(br[0]), .two_events(e2),
    .sysclk_edge, .perf_mon, .irq_zero, .irq_one, .irq_two);
  pec_sys_model pec_sys_model_inst (.pclk, .presetn, .arm, .sysclk_edge, .perf_mon);
  initial
    forever #25 pclk = ~pclk;
  // ----
  // tasks
  // ----
  task automatic summarize;
    $display("checks %0d failures %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do
    begin
      @(posedge pclk);
      i++;
      if (i > 20)
      begin
        n_fail++;
        summarize();
      end
    end
    while (pready !== 1'b1);
    q = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    `CHK("rdata", e, q)
  endtask
  task automatic pulse(input int n, input logic i0, input logic [15:0] a,
    input logic [15:0] b, input logic [2:0] c);
    @(posedge pclk);
    ins <= i0;
    e1 <= a;
    e2 <= b;
    br <= c;
    repeat (n) @(posedge pclk);
    ins <= 1'b0;
    e1 <= 16'h0;
    e2 <= 16'h0;
    br <= 3'h0;
  endtask
  // ----
  // sequence
  // ----
  initial
  begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    rd(12'h000, 32'h0);
    rd(12'h008, 32'h0);
    apb(1'b1, 12'h004, 32'h1234_abcd);
    rd(12'h004, 32'h1234_abcd);
    apb(1'b1, 12'h020, 32'hffff_ffff);
    rd(12'h020, 32'h0);
    `CHK("slverr", 1'b1, er)
    rd(12'h000, 32'h0);
    for (int c = 0; c < 16; c++)
    begin
      lo = 32'h1400 | (c << 4) | c;
      apb(1'b1, 12'h000, lo);
      apb(1'b1, 12'h004, 32'h0);
      pulse(2, 1'b0, ~(16'h1 << c), ~(16'h1 << c), 3'h0);
      pulse(3, 1'b0, 16'h1 << c, 16'h1 << c, 3'h0);
      rd(12'h004, (c == 8) ? 32'h0 : 32'h3);
      rd(12'h000, ((c == 1 || c == 11) ? 32'h0 : 32'h3_0000) | lo);
    end
    for (int j = 0; j < 3; j++)
    begin
      apb(1'b1, 12'h000, 32'h1080 | ((j == 2) ? 0 : j + 2));
      apb(1'b1, 12'h004, 32'h0);
      pulse(1, 1'b0, 16'h0, 16'h0, 3'h4);
      pulse(2, 1'b0, 16'h0, 16'h0, 3'h2);
      pulse(4, 1'b0, 16'h0, 16'h0, 3'h1);
      rd(12'h004, 32'h1 << j);
    end
    for (int k = 0; k < 8; k++)
      for (int m = 0; m < 5; m++)
      begin
        cpu_mode <= (m == 4) ? 2'h3 : m[1:0];
        lib <= (m == 4);
        apb(1'b1, 12'h000, 32'h8000_4000 | (k[2] << 30) | (k[1:0] << 8));
        apb(1'b1, 12'h004, 32'h0);
        pulse(3, 1'b1, 16'h0, 16'h0, 3'h0);
        kill = (m == 4) ? k[1] : (m == 3) ? k[2] : k[0] && (k != 7 || m == 0);
        rd(12'h004, kill ? 32'h0 : 32'h3_0000);
        rd(12'h010, (m == 4) ? 32'h7 : m);
      end
    cpu_mode <= 2'h3;
    lib <= 1'b0;
    apb(1'b1, 12'h000, 32'h4000_4000);
    apb(1'b1, 12'h004, 32'h0);
    cpu_mode <= 2'h0;
    repeat (5) @(posedge pclk);
    cpu_mode <= 2'h3;
    rd(12'h004, 32'h5_0000);
    apb(1'b1, 12'h004, 32'hfffe_00fe);
    apb(1'b1, 12'h000, 32'hbffe_b800);
    pulse(3, 1'b1, 16'h1, 16'h1, 3'h0);
    rd(12'h008, 32'h3800_0000);
    `CHK("irq", 3'h7, {irq_two, irq_one, irq_zero})
    rd(12'h004, 32'h0001_0101);
    apb(1'b1, 12'h000, 32'h0);
    rd(12'h008, 32'h3800_0000);
    apb(1'b1, 12'h00c, 32'h0800_0000);
    rd(12'h008, 32'h3000_0000);
    apb(1'b1, 12'h00c, 32'h3000_0000);
    rd(12'h008, 32'h0);
    apb(1'b1, 12'h004, 32'h00fe_fffe);
    apb(1'b1, 12'h000, 32'h80fe_ec00);
    pulse(3, 1'b1, 16'h1, 16'h1, 3'h0);
    rd(12'h008, 32'h3800_0000);
    rd(12'h004, 32'h0101_0001);
    rd(12'h000, 32'h8101_ec00);
    apb(1'b1, 12'h000, 32'h0000_040b);
    repeat (8) @(posedge pclk);
    arm <= 1'b1;
    @(posedge pclk);
    arm <= 1'b0;
    repeat (12) @(posedge pclk);
    rd(12'h000, 32'h0004_040b);
    summarize();
  end
endmodule // pec_top_tb_top
bind pec_top pec_monitor pec_monitor_inst (.pclk, .presetn, .psel, .penable, .pwrite,
  .paddr, .pwdata, .prdata, .pready, .pslverr, .irq_zero, .irq_one, .irq_two);
`default_nettype wire
